// ==== rtl/checkpoint_pkg.sv ====
package checkpoint_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CP     = 5;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned NUM_PARAMS = 5;

  // ---------------------------------------------------------------
  // register map (word indices)
  // ---------------------------------------------------------------
  localparam logic [11:0] PARAM_BASE   = 12'h0000;  // cp*5 + param index
  localparam logic [11:0] RESULT_BASE  = 12'h0040;  // cp*2 + result index
  localparam logic [11:0] FAULT_ADDR   = 12'h0060;  // second fault status word
  localparam logic [11:0] IRQ_STAT     = 12'h0061;  // sticky events, write one to clear
  localparam logic [11:0] IRQ_MASK     = 12'h0062;
  localparam logic [11:0] CTRL_ADDR    = 12'h0063;  // write bit0: start piece, bit1: end piece
  localparam logic [11:0] STATE_ADDR   = 12'h0064;  // bit0 piece active, bits 3:1 setpoints

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_END_BIT   = 1;
  localparam int unsigned FAULT_MAX_BIT  = 4;
  localparam int unsigned FAULT_MIN_BIT  = 5;
  localparam int unsigned IRQ_DONE_BIT   = 0;
  localparam int unsigned IRQ_MAX_BIT    = 1;
  localparam int unsigned IRQ_MIN_BIT    = 2;
  localparam int unsigned IRQ_SP_BIT     = 3;
  localparam logic [15:0] WORD_RST       = 16'h0000;
  localparam logic [15:0] MIN_INIT       = 16'hFFFF;
  localparam logic [15:0] SPEED_SCALE    = 16'h0100;  // speed = distance*scale/samples

  // ---------------------------------------------------------------
  // checkpoint types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    speed_window_type       = 3'b000,
    force_peak_window_type  = 3'b001,
    force_at_position_type  = 3'b011,
    position_at_force_type  = 3'b100,
    position_setpoint_type  = 3'b101
  } cp_type_t;

endpackage : checkpoint_pkg

// ==== rtl/press_checkpoint_evaluator.sv ====
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - each checkpoint has five parameter words; the fifth selects meaning of others.
// - checkpoint type is the low three bits of the fifth parameter.
// - types 011 force-at-position, 100 position-at-force, 001 force peak window.
// - types 000 speed over window, 101 setpoints at positions.
// - one or two measured values per piece land in two result words.
// - force type captures force when position reaches parameter one.
// - force type limits: parameter two lower, parameter three upper.
// - position type captures position when force reaches parameter one.
// - position type limits: parameter two lower, parameter three upper.
// - peak type tracks force between positions in parameters one and two.
// - peak type stores minimum in first result, maximum in second.
// - speed type measures speed between positions one and two into first result.
// - setpoint type fires setpoints one to three at parameter positions.
// - five checkpoints, five 16-bit rw parameters, two 16-bit ro results each.
// - over-limit in bit 4, under-limit in bit 5 of second fault word.
module press_checkpoint_evaluator
  import checkpoint_pkg::*;
#(
  parameter int unsigned CP_COUNT = NUM_CP
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // sample stream from the transducers, same clock domain
  input  wire logic              sample_valid_i,
  input  wire logic [WORD_W-1:0] sample_pos_i,
  input  wire logic [WORD_W-1:0] sample_force_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [WORD_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [WORD_W-1:0] reg_rdata_o,
  // outputs
  output logic      [2:0]        setpoint_o,
  output logic                   piece_done_o,
  output logic                   irq_o
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] param_r  [CP_COUNT][NUM_PARAMS];
  logic [WORD_W-1:0] res_a_r  [CP_COUNT];
  logic [WORD_W-1:0] res_b_r  [CP_COUNT];
  logic              hit_r    [CP_COUNT];  // capture done / window entered
  logic              fin_r    [CP_COUNT];  // window closed
  logic [WORD_W-1:0] cnt_r    [CP_COUNT];  // samples after the entry sample inside speed window
  logic [WORD_W-1:0] pos0_r   [CP_COUNT];  // position at window start
  logic              active_r;
  logic              done_r;
  logic [WORD_W-1:0] fault_r;
  logic [3:0]        stat_r;
  logic [3:0]        mask_r;
  logic [2:0]        sp_r;
  logic [WORD_W-1:0] rdata_r;
  logic              start_w;
  logic              end_w;
  logic              over_w;
  logic              under_w;
  logic [2:0]        sp_nxt;
  logic              stat_wr_w;
  logic              mask_wr_w;
  logic              sp_rise_w;
  logic [3:0]        stat_set_w;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // type field of a fifth parameter word
  function automatic cp_type_t cp_type(input logic [WORD_W-1:0] p5);
    return cp_type_t'(p5[2:0]);
  endfunction : cp_type

  // true when v lies between the two bounds, in either stroke direction
  function automatic logic in_window(input logic [WORD_W-1:0] v,
                                     input logic [WORD_W-1:0] a,
                                     input logic [WORD_W-1:0] b);
    return (a <= b) ? (v >= a && v <= b) : (v >= b && v <= a);
  endfunction : in_window

  // word index of parameter p of checkpoint c; shared by write and read decode
  function automatic logic [ADDR_W-1:0] param_addr(input int c, input int p);
    return PARAM_BASE + ADDR_W'(c * NUM_PARAMS + p);
  endfunction : param_addr

  // word index of result r (0 first, 1 second) of checkpoint c
  function automatic logic [ADDR_W-1:0] result_addr(input int c, input int r);
    return RESULT_BASE + ADDR_W'(c * 2 + r);
  endfunction : result_addr

  // only the capture types carry limit words; windows and setpoints do not
  function automatic logic has_limits(input cp_type_t t);
    return t == force_at_position_type || t == position_at_force_type;
  endfunction : has_limits

  // speed scaled per sample; a zero count yields zero rather than dividing
  function automatic logic [WORD_W-1:0] speed_of(input logic [WORD_W-1:0] p1,
                                                 input logic [WORD_W-1:0] p0,
                                                 input logic [WORD_W-1:0] n);
    logic [31:0] d;
    d = (p1 >= p0) ? 32'(p1 - p0) : 32'(p0 - p1);
    return (n == WORD_RST) ? WORD_RST : 16'((d * 32'(SPEED_SCALE)) / 32'(n));
  endfunction : speed_of

  // piece commands are write-only pulses; nothing of them is stored
  assign start_w = reg_wr_i && reg_addr_i == CTRL_ADDR && reg_wdata_i[CTRL_START_BIT];
  assign end_w   = reg_wr_i && reg_addr_i == CTRL_ADDR && reg_wdata_i[CTRL_END_BIT];

  // status and mask writes decoded once for the interrupt logic
  assign stat_wr_w = reg_wr_i && reg_addr_i == IRQ_STAT;
  assign mask_wr_w = reg_wr_i && reg_addr_i == IRQ_MASK;

  // ---------------------------------------------------------------
  // parameter writes
  // ---------------------------------------------------------------
  // five words per checkpoint, packed at cp*5 + index
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < CP_COUNT; c++) begin
        for (int p = 0; p < NUM_PARAMS; p++) begin
          param_r[c][p] <= WORD_RST;
        end
      end
    end else if (reg_wr_i) begin
      for (int c = 0; c < CP_COUNT; c++) begin
        for (int p = 0; p < NUM_PARAMS; p++) begin
          if (reg_addr_i == param_addr(c, p)) begin
            param_r[c][p] <= reg_wdata_i;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // piece sequencing
  // ---------------------------------------------------------------
  // a piece runs from the start command to the end command
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_r <= 1'b0;
    end else if (start_w) begin
      active_r <= 1'b1;
    end else if (end_w) begin
      active_r <= 1'b0;
    end
  end

  // the done pulse needs a running piece, so a stray end write stays silent
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_r <= 1'b0;
    end else begin
      done_r <= end_w && active_r;
    end
  end

  // ---------------------------------------------------------------
  // per-checkpoint measurement
  // ---------------------------------------------------------------
  // results are reset at piece start, a peak minimum to full scale, so a stale value never survives
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < CP_COUNT; c++) begin
        res_a_r[c] <= WORD_RST;
        res_b_r[c] <= WORD_RST;
        hit_r[c]   <= 1'b0;
        fin_r[c]   <= 1'b0;
        cnt_r[c]   <= WORD_RST;
        pos0_r[c]  <= WORD_RST;
      end
    end else if (start_w) begin
      // a peak minimum starts at full scale so the first window sample wins
      for (int c = 0; c < CP_COUNT; c++) begin
        res_a_r[c] <= (cp_type(param_r[c][4]) == force_peak_window_type) ? MIN_INIT : WORD_RST;
        res_b_r[c] <= WORD_RST;
        hit_r[c]   <= 1'b0;
        fin_r[c]   <= 1'b0;
        cnt_r[c]   <= WORD_RST;
        pos0_r[c]  <= WORD_RST;
      end
    end else if (active_r && sample_valid_i) begin
      for (int c = 0; c < CP_COUNT; c++) begin
        case (cp_type(param_r[c][4]))
          force_at_position_type: begin
            if (!hit_r[c] && sample_pos_i >= param_r[c][0]) begin
              res_a_r[c] <= sample_force_i;
              hit_r[c]   <= 1'b1;
            end
          end
          position_at_force_type: begin
            // one capture per piece; later samples above threshold are ignored
            if (!hit_r[c] && sample_force_i >= param_r[c][0]) begin
              res_a_r[c] <= sample_pos_i;
              hit_r[c]   <= 1'b1;
            end
          end
          force_peak_window_type: begin
            // the window may be entered more than once; extremes keep accumulating
            if (in_window(sample_pos_i, param_r[c][0], param_r[c][1])) begin
              hit_r[c] <= 1'b1;
              if (sample_force_i < res_a_r[c]) begin
                res_a_r[c] <= sample_force_i;
              end
              if (sample_force_i > res_b_r[c]) begin
                res_b_r[c] <= sample_force_i;
              end
            end
          end
          speed_window_type: begin
            // speed is distance over samples spent inside the window
            if (!fin_r[c] && in_window(sample_pos_i, param_r[c][0], param_r[c][1])) begin
              if (!hit_r[c]) begin
                pos0_r[c] <= sample_pos_i;
                hit_r[c]  <= 1'b1;
              end else begin
                cnt_r[c]   <= cnt_r[c] + 16'h0001;
                res_a_r[c] <= speed_of(sample_pos_i, pos0_r[c], cnt_r[c] + 16'h0001);
              end
            end else if (hit_r[c]) begin
              fin_r[c] <= 1'b1;
            end
          end
          default: begin
            // reserved type codes measure nothing
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // setpoints
  // ---------------------------------------------------------------
  // any setpoint checkpoint drives all three outputs; they drop at piece start
  always_comb begin
    sp_nxt = sp_r;
    for (int c = 0; c < CP_COUNT; c++) begin
      if (cp_type(param_r[c][4]) == position_setpoint_type) begin
        for (int s = 0; s < 3; s++) begin
          if (sample_pos_i >= param_r[c][s]) begin
            sp_nxt[s] = 1'b1;
          end
        end
      end
    end
  end

  // setpoints only rise on a valid sample of a running piece; a start clears them
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_r <= 3'b000;
    end else if (start_w) begin
      sp_r <= 3'b000;
    end else if (active_r && sample_valid_i) begin
      sp_r <= sp_nxt;
    end
  end

  // ---------------------------------------------------------------
  // limit check at piece end
  // ---------------------------------------------------------------
  // only force and position types carry limits; unreached capture is under
  always_comb begin
    over_w  = 1'b0;
    under_w = 1'b0;
    for (int c = 0; c < CP_COUNT; c++) begin
      if (has_limits(cp_type(param_r[c][4]))) begin
        if (res_a_r[c] > param_r[c][2]) begin
          over_w = 1'b1;
        end
        if (!hit_r[c] || res_a_r[c] < param_r[c][1]) begin
          under_w = 1'b1;
        end
      end
    end
  end

  // fault bits stand until the next start so software may read them late
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_r <= WORD_RST;
    end else if (start_w) begin
      fault_r <= WORD_RST;
    end else if (done_r) begin
      fault_r[FAULT_MAX_BIT] <= over_w;
      fault_r[FAULT_MIN_BIT] <= under_w;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  // a start in the same cycle clears the setpoints, so no rise is reported then
  assign sp_rise_w = |(sp_nxt & ~sp_r) && active_r && sample_valid_i && !start_w;

  // event vector in status bit order
  always_comb begin
    stat_set_w               = 4'h0;
    stat_set_w[IRQ_DONE_BIT] = done_r;
    stat_set_w[IRQ_MAX_BIT]  = done_r && over_w;
    stat_set_w[IRQ_MIN_BIT]  = done_r && under_w;
    stat_set_w[IRQ_SP_BIT]   = sp_rise_w;
  end

  // mask is plain read/write; it gates the output but never the status bits
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_r <= 4'h0;
    end else if (mask_wr_w) begin
      mask_r <= reg_wdata_i[3:0];
    end
  end

  // set wins over a write-one clear in the same cycle, so no event is lost
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_r <= 4'h0;
    end else begin
      stat_r <= (stat_r & ~(stat_wr_w ? reg_wdata_i[3:0] : 4'h0)) | stat_set_w;
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  // data appears in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= WORD_RST;
    end else if (reg_rd_i) begin
      // later matches override this default
      rdata_r <= WORD_RST;
      for (int c = 0; c < CP_COUNT; c++) begin
        for (int p = 0; p < NUM_PARAMS; p++) begin
          if (reg_addr_i == param_addr(c, p)) begin
            rdata_r <= param_r[c][p];
          end
        end
        if (reg_addr_i == result_addr(c, 0)) begin
          rdata_r <= res_a_r[c];
        end
        if (reg_addr_i == result_addr(c, 1)) begin
          rdata_r <= res_b_r[c];
        end
      end
      case (reg_addr_i)
        FAULT_ADDR: rdata_r <= fault_r;
        IRQ_STAT:   rdata_r <= {12'h000, stat_r};
        IRQ_MASK:   rdata_r <= {12'h000, mask_r};
        STATE_ADDR: rdata_r <= {12'h000, sp_r, active_r};
        default: begin
          // control word reads as zero; it holds no state of its own
        end
      endcase
    end
  end

  // outputs straight from their registers, irq as a level of status and mask
  assign reg_rdata_o  = rdata_r;
  assign setpoint_o   = sp_r;
  assign piece_done_o = done_r;
  assign irq_o        = |(stat_r & mask_r);

endmodule : press_checkpoint_evaluator

`default_nettype wire

// ==== verification/press_checkpoint_evaluator_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module cp_eval_chk
  import checkpoint_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              sample_valid_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [WORD_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [WORD_W-1:0] reg_rdata_o,
  input  wire logic [2:0]        setpoint_o,
  input  wire logic              piece_done_o,
  input  wire logic              irq_o
);
  // ---------------------------------------------------------------
  // helper logic and properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] mask_r;
  logic       start_w;
  logic       end_w;
  logic       unmapped;
  // shadow of the mask so irq can be tied to what software allowed
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) mask_r <= 4'h0;
    else if (reg_wr_i && reg_addr_i == IRQ_MASK) mask_r <= reg_wdata_i[3:0];
  end
  // decoded control writes and holes in the map
  assign start_w  = reg_wr_i && reg_addr_i == CTRL_ADDR && reg_wdata_i[CTRL_START_BIT];
  assign end_w    = reg_wr_i && reg_addr_i == CTRL_ADDR && reg_wdata_i[CTRL_END_BIT];
  assign unmapped = reg_addr_i > STATE_ADDR || (reg_addr_i > 12'h018 && reg_addr_i < RESULT_BASE)
                    || (reg_addr_i > 12'h049 && reg_addr_i < FAULT_ADDR);
  a_rdata_hold:
    assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o)) else $error("read data moved");
  a_unmapped_zero:
    assert property (reg_rd_i && unmapped |=> reg_rdata_o == 16'h0000) else $error("hole read");
  a_done_cause:
    assert property (piece_done_o |-> $past(end_w)) else $error("done without end write");
  a_done_single:
    assert property (piece_done_o |=> !piece_done_o) else $error("done longer than a cycle");
  a_start_clears:
    assert property (start_w |=> setpoint_o == 3'b000) else $error("setpoints kept on start");
  a_setpoint_latch:
    assert property (|($past(setpoint_o) & ~setpoint_o) |-> $past(start_w))
      else $error("setpoint dropped without start");
  a_setpoint_cause:
    assert property (|(setpoint_o & ~$past(setpoint_o)) |-> $past(sample_valid_i))
      else $error("setpoint rose without sample");
  a_irq_masked:
    assert property (irq_o |-> mask_r != 4'h0) else $error("irq with all masked");
  a_irq_done:
    assert property (piece_done_o && mask_r[IRQ_DONE_BIT] |-> ##[0:1] irq_o)
      else $error("done event gave no irq");
  c_done:   cover property (piece_done_o);
  c_irq:    cover property ($rose(irq_o));
  c_sp_all: cover property (setpoint_o == 3'b111);
endmodule : cp_eval_chk

bind press_checkpoint_evaluator cp_eval_chk i_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sample_valid_i(sample_valid_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .setpoint_o(setpoint_o),
  .piece_done_o(piece_done_o), .irq_o(irq_o)
);
`default_nettype wire

// ==== verification/transducer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module transducer_model
  import checkpoint_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              send_i,
  input  wire logic [WORD_W-1:0] pos_i,
  input  wire logic [WORD_W-1:0] force_i,
  output logic                   sample_valid_o,
  output logic      [WORD_W-1:0] sample_pos_o,
  output logic      [WORD_W-1:0] sample_force_o
);
  // ---------------------------------------------------------------
  // sample stream
  // ---------------------------------------------------------------
  // one strobed sample per request; between strobes the data lines toggle
  // so a block that reads them outside the strobe sees garbage
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_valid_o <= 1'b0;
      sample_pos_o   <= 16'h0000;
      sample_force_o <= 16'h0000;
    end else begin
      sample_valid_o <= send_i;
      sample_pos_o   <= send_i ? pos_i : ~sample_pos_o;
      sample_force_o <= send_i ? force_i : ~sample_force_o;
    end
  end
endmodule : transducer_model
`default_nettype wire

// ==== verification/press_checkpoint_evaluator_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module press_checkpoint_evaluator_bench import checkpoint_pkg::*;;
  // ---------------------------------------------------------------
  // signals, tables, instances
  // ---------------------------------------------------------------
  logic              sys_clk_i, rst_n_i, send, sv, reg_wr_i, reg_rd_i, piece_done_o, irq_o;
  logic [WORD_W-1:0] spos, sforce, sp, sf, reg_wdata_i, reg_rdata_o;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [2:0]        setpoint_o;
  int                n_errors = 0;
  int                cmp_count = 0;
  // upper type bits set on purpose: only the low three may decode
  logic [15:0] cfg [25] = '{16'h0064, 16'h0032, 16'h0050, 16'hA5A5, 16'hFFF3,
                            16'h00C8, 16'h008C, 16'h00C8, 16'h5A5A, 16'hFFFC,
                            16'h0032, 16'h0096, 16'h0000, 16'h0000, 16'h0001,
                            16'h0032, 16'h0096, 16'h0000, 16'h0000, 16'h0000,
                            16'h003C, 16'h0078, 16'h008C, 16'h0000, 16'h0005};
  logic [15:0] s_pos [5] = '{16'h0014, 16'h003C, 16'h0064, 16'h0082, 16'h00A5};
  logic [15:0] s_frc [5] = '{16'h000A, 16'h0028, 16'h005A, 16'h00D2, 16'h012C};
  logic [15:0] s_sp  [5] = '{16'h0000, 16'h0001, 16'h0001, 16'h0003, 16'h0007};
  transducer_model i_src (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .send_i(send),
    .pos_i(spos), .force_i(sforce), .sample_valid_o(sv), .sample_pos_o(sp),
    .sample_force_o(sf));
  press_checkpoint_evaluator i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .sample_valid_i(sv), .sample_pos_i(sp), .sample_force_i(sf), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .setpoint_o(setpoint_o), .piece_done_o(piece_done_o),
    .irq_o(irq_o));
  // free running 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic summarize;
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr
  // read data appear in the cycle after the strobe and hold until the next read, so look there
  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o, exp);
  endtask : rd_chk
  task automatic samp(input logic [15:0] p, input logic [15:0] f);
    @(posedge sys_clk_i);
    send   <= 1'b1;
    spos   <= p;
    sforce <= f;
    @(posedge sys_clk_i);
    send <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask : samp
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int i;
    {rst_n_i, send, reg_wr_i, reg_rd_i} = 4'h0;
    {spos, sforce, reg_wdata_i} = 48'h0;
    reg_addr_i = 12'h000;
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 25; i++) rd_chk(PARAM_BASE + 12'(i), WORD_RST);
    wr(RESULT_BASE, 16'h1234);
    rd_chk(RESULT_BASE, WORD_RST);
    rd_chk(12'h100, 16'h0000);
    for (i = 0; i < 25; i++) wr(PARAM_BASE + 12'(i), cfg[i]);
    for (i = 0; i < 25; i++) rd_chk(PARAM_BASE + 12'(i), cfg[i]);
    wr(CTRL_ADDR, 16'h0001);
    check({13'h0000, setpoint_o}, 16'h0000);
    for (i = 0; i < 5; i++) begin
      samp(s_pos[i], s_frc[i]);
      check({13'h0000, setpoint_o}, s_sp[i]);
    end
    rd_chk(STATE_ADDR, 16'h000F);
    wr(CTRL_ADDR, 16'h0002);
    for (i = 0; i < 8 && piece_done_o !== 1'b1; i++) @(posedge sys_clk_i) #1;
    check({15'h0000, piece_done_o}, 16'h0001);
    if (piece_done_o !== 1'b1) summarize();
    repeat (2) @(posedge sys_clk_i);
    rd_chk(RESULT_BASE, 16'h005A);
    rd_chk(RESULT_BASE + 12'h002, 16'h0082);
    rd_chk(RESULT_BASE + 12'h004, 16'h0028);
    rd_chk(RESULT_BASE + 12'h005, 16'h00D2);
    rd_chk(RESULT_BASE + 12'h006, 16'h2300);
    rd_chk(FAULT_ADDR, 16'h0030);
    rd_chk(IRQ_STAT, 16'h000F);
    check({15'h0000, irq_o}, 16'h0000);
    wr(IRQ_MASK, 16'h0002);
    check({15'h0000, irq_o}, 16'h0001);
    wr(IRQ_STAT, 16'h0002);
    check({15'h0000, irq_o}, 16'h0000);
    rd_chk(IRQ_STAT, 16'h000D);
    wr(CTRL_ADDR, 16'h0001);
    check({13'h0000, setpoint_o}, 16'h0000);
    rd_chk(RESULT_BASE + 12'h004, MIN_INIT);
    rd_chk(FAULT_ADDR, 16'h0000);
    // second piece without samples: both captures miss, done reaches the irq
    wr(IRQ_STAT, 16'h000F);
    wr(IRQ_MASK, 16'h0001);
    check({15'h0000, irq_o}, 16'h0000);
    rd_chk(STATE_ADDR, 16'h0001);
    wr(CTRL_ADDR, 16'h0002);
    check({15'h0000, piece_done_o}, 16'h0001);
    rd_chk(FAULT_ADDR, 16'h0020);
    check({15'h0000, irq_o}, 16'h0001);
    rd_chk(IRQ_STAT, 16'h0005);
    summarize();
  end
endmodule : press_checkpoint_evaluator_bench
`default_nettype wire
